// File: rtl/jtmap_pkg.sv
// Constants for the test access port with memory access instructions.
// Assumes one 5-bit instruction register and data registers of up to 32 bits.
package jtmap_pkg;

  // ==========================================================================
  // Instruction codes
  localparam logic [4:0] JTMAP_IR_IDCODE = 5'h00;
  localparam logic [4:0] JTMAP_IR_USERCODE = 5'h03;
  localparam logic [4:0] JTMAP_IR_LOAD_ADDR = 5'h04;
  localparam logic [4:0] JTMAP_IR_READ_DATA = 5'h05;
  localparam logic [4:0] JTMAP_IR_WRITE_DATA = 5'h06;
  localparam logic [4:0] JTMAP_IR_REBOOT = 5'h07;
  localparam logic [4:0] JTMAP_IR_SAVE = 5'h08;
  localparam logic [4:0] JTMAP_IR_NVM_PAGE_ON = 5'h09;
  localparam logic [4:0] JTMAP_IR_NVM_PAGE_OFF = 5'h0A;
  localparam logic [4:0] JTMAP_IR_CUSTOMER_NVM_ON = 5'h0B;
  localparam logic [4:0] JTMAP_IR_CUSTOMER_NVM_OFF = 5'h0C;
  localparam logic [4:0] JTMAP_IR_BYPASS = 5'h1F;

  // ==========================================================================
  // Widths and fixed values
  localparam int JTMAP_IR_W = 5;
  localparam int JTMAP_DR_W = 32;
  localparam int JTMAP_MEM_W = 8;
  localparam logic [4:0] JTMAP_IR_CAPTURE = 5'h01;
  localparam logic [4:0] JTMAP_LEN_BYPASS = 5'h00;
  localparam logic [4:0] JTMAP_LEN_MEM = 5'h07;
  localparam logic [4:0] JTMAP_LEN_WORD = 5'h1F;
  localparam logic [15:0] JTMAP_USER_PAD = 16'h0000;

  // Identity fields, values arbitrary
  localparam logic [10:0] JTMAP_ID_MAKER = 11'h055;
  localparam logic [15:0] JTMAP_ID_PART = 16'h1234;
  localparam logic [3:0] JTMAP_ID_VERSION = 4'h1;

  // ==========================================================================
  // Controller states
  typedef enum logic [3:0] {
    JTMAP_TLR = 4'h0,
    JTMAP_IDLE = 4'h1,
    JTMAP_SEL_DR = 4'h2,
    JTMAP_CAP_DR = 4'h3,
    JTMAP_SHIFT_DR = 4'h4,
    JTMAP_EXIT1_DR = 4'h5,
    JTMAP_PAUSE_DR = 4'h6,
    JTMAP_EXIT2_DR = 4'h7,
    JTMAP_UPD_DR = 4'h8,
    JTMAP_SEL_IR = 4'h9,
    JTMAP_CAP_IR = 4'hA,
    JTMAP_SHIFT_IR = 4'hB,
    JTMAP_EXIT1_IR = 4'hC,
    JTMAP_PAUSE_IR = 4'hD,
    JTMAP_EXIT2_IR = 4'hE,
    JTMAP_UPD_IR = 4'hF
  } jtmap_state_t;

endpackage : jtmap_pkg

// File: rtl/jtmap_tap.sv
// Test access port with memory access, reboot, save and page instructions.
// Assumes tck from the host, resetn as power-on reset, memory logic on clk.
`timescale 1ns/1ns

module jtmap_tap (
  input wire logic clk,
  input wire logic resetn,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic [jtmap_pkg::JTMAP_MEM_W-1:0] mem_rd_data,
  input wire logic [7:0] user_id,
  input wire logic [7:0] bus_id,
  output logic [jtmap_pkg::JTMAP_MEM_W-1:0] mem_addr,
  output logic [jtmap_pkg::JTMAP_MEM_W-1:0] mem_wr_data,
  output logic mem_rd_stb,
  output logic mem_wr_stb,
  output logic reboot_stb,
  output logic save_stb,
  output logic nvm_page_on,
  output logic customer_nvm_on
);
  import jtmap_pkg::*;

  // ==========================================================================
  // Controller (tck domain)
  jtmap_state_t state;
  jtmap_state_t next_state;

  always_comb begin
    unique case (state)
      JTMAP_TLR: next_state = tms ? JTMAP_TLR : JTMAP_IDLE;
      JTMAP_IDLE: next_state = tms ? JTMAP_SEL_DR : JTMAP_IDLE;
      JTMAP_SEL_DR: next_state = tms ? JTMAP_SEL_IR : JTMAP_CAP_DR;
      JTMAP_CAP_DR: next_state = tms ? JTMAP_EXIT1_DR : JTMAP_SHIFT_DR;
      JTMAP_SHIFT_DR: next_state = tms ? JTMAP_EXIT1_DR : JTMAP_SHIFT_DR;
      JTMAP_EXIT1_DR: next_state = tms ? JTMAP_UPD_DR : JTMAP_PAUSE_DR;
      JTMAP_PAUSE_DR: next_state = tms ? JTMAP_EXIT2_DR : JTMAP_PAUSE_DR;
      JTMAP_EXIT2_DR: next_state = tms ? JTMAP_UPD_DR : JTMAP_SHIFT_DR;
      JTMAP_UPD_DR: next_state = tms ? JTMAP_SEL_DR : JTMAP_IDLE;
      JTMAP_SEL_IR: next_state = tms ? JTMAP_TLR : JTMAP_CAP_IR;
      JTMAP_CAP_IR: next_state = tms ? JTMAP_EXIT1_IR : JTMAP_SHIFT_IR;
      JTMAP_SHIFT_IR: next_state = tms ? JTMAP_EXIT1_IR : JTMAP_SHIFT_IR;
      JTMAP_EXIT1_IR: next_state = tms ? JTMAP_UPD_IR : JTMAP_PAUSE_IR;
      JTMAP_PAUSE_IR: next_state = tms ? JTMAP_EXIT2_IR : JTMAP_PAUSE_IR;
      JTMAP_EXIT2_IR: next_state = tms ? JTMAP_UPD_IR : JTMAP_SHIFT_IR;
      JTMAP_UPD_IR: next_state = tms ? JTMAP_SEL_DR : JTMAP_IDLE;
    endcase
  end

  always_ff @(posedge tck or negedge resetn) begin
    if (!resetn) begin
      state <= JTMAP_TLR;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // Instruction register
  // shift stage and latch
  logic [JTMAP_IR_W-1:0] ir_sh;
  logic [JTMAP_IR_W-1:0] ir;

  // capture and shift of instruction stage
  always_ff @(posedge tck or negedge resetn) begin
    if (!resetn) begin
      ir_sh <= JTMAP_IR_CAPTURE;
    end else if (state == JTMAP_CAP_IR) begin
      ir_sh <= JTMAP_IR_CAPTURE;
    end else if (state == JTMAP_SHIFT_IR) begin
      ir_sh <= {tdi, ir_sh[JTMAP_IR_W-1:1]};
    end
  end

  // latch on falling edge; forced identity code
  always_ff @(negedge tck or negedge resetn) begin
    if (!resetn) begin
      ir <= JTMAP_IR_IDCODE;
    end else if (state == JTMAP_TLR) begin
      ir <= JTMAP_IR_IDCODE;
    end else if (state == JTMAP_UPD_IR) begin
      ir <= ir_sh;
    end
  end

  // ==========================================================================
  // Data register selection
  wire sel_id = (ir == JTMAP_IR_IDCODE);
  wire sel_user = (ir == JTMAP_IR_USERCODE);
  wire sel_addr = (ir == JTMAP_IR_LOAD_ADDR);
  wire sel_rd = (ir == JTMAP_IR_READ_DATA);
  wire sel_wr = (ir == JTMAP_IR_WRITE_DATA);
  wire sel_mem = sel_addr | sel_rd | sel_wr;
  wire [4:0] dr_len_m1 = (sel_id | sel_user) ? JTMAP_LEN_WORD : (sel_mem ? JTMAP_LEN_MEM : JTMAP_LEN_BYPASS);

  wire [JTMAP_DR_W-1:0] id_word = {JTMAP_ID_VERSION, JTMAP_ID_PART, JTMAP_ID_MAKER, 1'b1};

  logic [JTMAP_DR_W-1:0] dr_sh;
  logic [JTMAP_DR_W-1:0] next_shift;
  logic [JTMAP_DR_W-1:0] user_word;
  logic [JTMAP_MEM_W-1:0] rd_buf;

  // shift path length set by instruction
  genvar gi;
  generate
    for (gi = 0; gi < JTMAP_DR_W; gi++) begin : g_shift
      if (gi == JTMAP_DR_W - 1) begin : g_top
        assign next_shift[gi] = (dr_len_m1 == 5'(gi)) ? tdi : 1'b0;
      end else begin : g_mid
        assign next_shift[gi] = (dr_len_m1 == 5'(gi)) ? tdi : dr_sh[gi+1];
      end
    end
  endgenerate

  wire [JTMAP_DR_W-1:0] cap_word = sel_id ? id_word : (sel_user ? user_word : {24'h000000, rd_buf});
  // addr and write registers have no parallel load
  wire cap_load = sel_id | sel_user | sel_rd;

  // capture of identity, user-code and read data
  always_ff @(posedge tck or negedge resetn) begin
    if (!resetn) begin
      dr_sh <= '0;
    end else if (state == JTMAP_CAP_DR && cap_load) begin
      dr_sh <= cap_word;
    end else if (state == JTMAP_CAP_DR && !sel_mem) begin
      dr_sh <= '0;
    end else if (state == JTMAP_SHIFT_DR) begin
      dr_sh <= next_shift;
    end
  end

  // ==========================================================================
  // TDO driven on falling edge
  wire shifting = (state == JTMAP_SHIFT_DR) | (state == JTMAP_SHIFT_IR);
  // instruction stage on TDO in shift-IR
  wire tdo_bit = (state == JTMAP_SHIFT_IR) ? ir_sh[0] : dr_sh[0];

  always_ff @(negedge tck or negedge resetn) begin
    if (!resetn) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      tdo <= tdo_bit;
      tdo_oe <= shifting;
    end
  end

  // ==========================================================================
  // Update latches and events to the system side
  logic [JTMAP_MEM_W-1:0] ev_data;
  logic [JTMAP_IR_W-1:0] ev_code;
  logic ev_tog;
  wire ir_event = (state == JTMAP_UPD_IR) & (ir_sh != JTMAP_IR_LOAD_ADDR) & (ir_sh != JTMAP_IR_WRITE_DATA);
  wire dr_event = (state == JTMAP_UPD_DR) & sel_mem;

  // falling-edge update latch; memory access and instruction events
  always_ff @(negedge tck or negedge resetn) begin
    if (!resetn) begin
      ev_data <= '0;
      ev_code <= JTMAP_IR_IDCODE;
      ev_tog <= 1'b0;
    end else if (dr_event) begin
      ev_data <= dr_sh[JTMAP_MEM_W-1:0];
      ev_code <= ir;
      ev_tog <= ~ev_tog;
    end else if (ir_event) begin
      ev_code <= ir_sh;
      ev_tog <= ~ev_tog;
    end
  end

  // ==========================================================================
  // System side (clk domain)
  logic tog_s1;
  logic tog_s2;
  logic tog_s3;
  logic rd_pend;
  wire ev_seen = tog_s2 ^ tog_s3;
  wire ev_addr = ev_seen & (ev_code == JTMAP_IR_LOAD_ADDR);
  wire ev_rd = ev_seen & (ev_code == JTMAP_IR_READ_DATA);
  wire ev_wr = ev_seen & (ev_code == JTMAP_IR_WRITE_DATA);
  wire ev_reboot = ev_seen & (ev_code == JTMAP_IR_REBOOT);
  wire ev_save = ev_seen & (ev_code == JTMAP_IR_SAVE);
  wire ev_pg_on = ev_seen & (ev_code == JTMAP_IR_NVM_PAGE_ON);
  wire ev_pg_off = ev_seen & (ev_code == JTMAP_IR_NVM_PAGE_OFF);
  wire ev_cu_on = ev_seen & (ev_code == JTMAP_IR_CUSTOMER_NVM_ON);
  wire ev_cu_off = ev_seen & (ev_code == JTMAP_IR_CUSTOMER_NVM_OFF);
  wire ev_user = ev_seen & (ev_code == JTMAP_IR_USERCODE);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
    end else begin
      tog_s1 <= ev_tog;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mem_addr <= '0;
      mem_wr_data <= '0;
      mem_rd_stb <= 1'b0;
      mem_wr_stb <= 1'b0;
      rd_pend <= 1'b0;
      rd_buf <= '0;
    end else begin
      mem_addr <= ev_addr ? ev_data : mem_addr;
      mem_wr_data <= ev_wr ? ev_data : mem_wr_data;
      mem_rd_stb <= ev_rd;
      mem_wr_stb <= ev_wr;
      rd_pend <= mem_rd_stb;
      rd_buf <= rd_pend ? mem_rd_data : rd_buf;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reboot_stb <= 1'b0;
      save_stb <= 1'b0;
      user_word <= '0;
    end else begin
      reboot_stb <= ev_reboot;
      save_stb <= ev_save;
      user_word <= ev_user ? {JTMAP_USER_PAD, bus_id, user_id} : user_word;
    end
  end

  // page on and off; customer space only from page
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      nvm_page_on <= 1'b0;
      customer_nvm_on <= 1'b0;
    end else begin
      nvm_page_on <= ev_pg_on | (nvm_page_on & ~ev_pg_off);
      customer_nvm_on <= (ev_cu_on & nvm_page_on) | (customer_nvm_on & ~ev_cu_off & ~ev_pg_off);
    end
  end

  // ==========================================================================
  // Checks
  property p_cap_dr;
    @(posedge tck) disable iff (!resetn)
    state == JTMAP_CAP_DR |=> state == ($past(tms) ? JTMAP_EXIT1_DR : JTMAP_SHIFT_DR);
  endproperty
  a_cap_dr: assert property (p_cap_dr) else $error("capture-DR exit wrong");

  property p_keep_addr;
    @(posedge tck) disable iff (!resetn)
    (state == JTMAP_CAP_DR && sel_addr) |=> dr_sh == $past(dr_sh);
  endproperty
  a_keep_addr: assert property (p_keep_addr) else $error("address register changed on capture");

  property p_shift_word;
    @(posedge tck) disable iff (!resetn)
    (state == JTMAP_SHIFT_DR && sel_id) |=> dr_sh == {$past(tdi), $past(dr_sh[31:1])};
  endproperty
  a_shift_word: assert property (p_shift_word) else $error("word shift wrong");

  property p_pause_hold;
    @(posedge tck) disable iff (!resetn)
    state == JTMAP_PAUSE_DR ##1 state == JTMAP_PAUSE_DR |-> dr_sh == $past(dr_sh);
  endproperty
  a_pause_hold: assert property (p_pause_hold) else $error("pause-DR changed data");

  property p_sel_ir;
    @(posedge tck) disable iff (!resetn)
    (state == JTMAP_SEL_IR && tms) |=> state == JTMAP_TLR;
  endproperty
  a_sel_ir: assert property (p_sel_ir) else $error("select-IR escape wrong");

  property p_cap_ir;
    @(posedge tck) disable iff (!resetn)
    state == JTMAP_CAP_IR |=> ir_sh == JTMAP_IR_CAPTURE;
  endproperty
  a_cap_ir: assert property (p_cap_ir) else $error("capture-IR value wrong");

  property p_upd_ir;
    @(posedge tck) disable iff (!resetn)
    state == JTMAP_UPD_IR |=> ir == $past(ir_sh);
  endproperty
  a_upd_ir: assert property (p_upd_ir) else $error("instruction not latched");

  property p_tlr_id;
    @(posedge tck) disable iff (!resetn)
    state == JTMAP_TLR |=> ir == JTMAP_IR_IDCODE;
  endproperty
  a_tlr_id: assert property (p_tlr_id) else $error("identity code not forced");

  property p_five_tms;
    @(posedge tck) disable iff (!resetn)
    tms [*5] |=> state == JTMAP_TLR;
  endproperty
  a_five_tms: assert property (p_five_tms) else $error("five TMS high missed reset");

  property p_sel_dr;
    @(posedge tck) disable iff (!resetn)
    (state == JTMAP_SEL_DR && !tms) |=> state == JTMAP_CAP_DR;
  endproperty
  a_sel_dr: assert property (p_sel_dr) else $error("select-DR entry wrong");

  property p_customer;
    @(posedge clk) disable iff (!resetn)
    (ev_cu_on && !nvm_page_on) |=> !customer_nvm_on;
  endproperty
  a_customer: assert property (p_customer) else $error("customer space without page");

  property p_exit1_dr;
    @(posedge tck) disable iff (!resetn)
    state == JTMAP_EXIT1_DR |=> state == ($past(tms) ? JTMAP_UPD_DR : JTMAP_PAUSE_DR);
  endproperty
  a_exit1_dr: assert property (p_exit1_dr) else $error("exit1-DR exit wrong");

  property p_exit2_dr;
    @(posedge tck) disable iff (!resetn)
    state == JTMAP_EXIT2_DR |=> state == ($past(tms) ? JTMAP_UPD_DR : JTMAP_SHIFT_DR);
  endproperty
  a_exit2_dr: assert property (p_exit2_dr) else $error("exit2-DR exit wrong");

  property p_exit1_ir;
    @(posedge tck) disable iff (!resetn)
    state == JTMAP_EXIT1_IR |=> state == ($past(tms) ? JTMAP_UPD_IR : JTMAP_PAUSE_IR);
  endproperty
  a_exit1_ir: assert property (p_exit1_ir) else $error("exit1-IR exit wrong");

  property p_pause_ir;
    @(posedge tck) disable iff (!resetn)
    state == JTMAP_PAUSE_IR |=> ir_sh == $past(ir_sh);
  endproperty
  a_pause_ir: assert property (p_pause_ir) else $error("pause-IR changed instruction");

endmodule : jtmap_tap

// File: tb/jtmap_host.sv
// Host model for the test access port: drives tck, tms and tdi, samples tdo.
// Assumes tdo changes on tck falls; tck stands low between frames.
`timescale 1ns/1ns

module jtmap_host (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe
);
  int oe_bad;

  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    oe_bad = 0;
  end

  // ==========================================================================
  // One tck period, tdo taken at the rise
  task automatic tick(input logic m, input logic d, input logic chk, output logic q);
    tms = m;
    tdi = d;
    #8;
    tck = 1'b1;
    q = tdo;
    if (chk && tdo_oe !== 1'b1) begin
      oe_bad++;
    end
    #7;
    tck = 1'b0;
  endtask : tick

  // Idle bit on tdi is the inverse of the last one
  task automatic step(input logic m);
    logic q;
    tick(m, ~tdi, 1'b0, q);
  endtask : step

  task automatic go_reset();
    repeat (5) step(1'b1);
    step(1'b0);
  endtask : go_reset

  // ==========================================================================
  // Scan from idle back to idle, optional pause after bit brk
  task automatic scan(input logic ir, input int n, input logic [31:0] din, input int brk,
                      output logic [31:0] dout);
    logic q;
    dout = '0;
    step(1'b1);
    if (ir) begin
      step(1'b1);
    end
    step(1'b0);
    step(1'b0);
    for (int i = 0; i < n; i++) begin
      tick((i == n - 1) || (i == brk), din[i], 1'b1, q);
      dout[i] = q;
      if (i == brk && i < n - 1) begin
        step(1'b0);
        step(1'b0);
        step(1'b1);
        step(1'b0);
      end
    end
    step(1'b1);
    step(1'b0);
  endtask : scan
endmodule : jtmap_host

// File: tb/jtmap_tap_tb.sv
// Self-checking bench for the test access port with memory instructions.
// Assumes the host model as link partner and a memory answering by address.
`timescale 1ns/1ns

module jtmap_tap_tb;
  import jtmap_pkg::*;

  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic tck, tms, tdi, tdo, tdo_oe;
  logic [7:0] mem_rd_data;
  logic [7:0] user_id;
  logic [7:0] bus_id;
  logic [7:0] mem_addr, mem_wr_data, last_wr;
  logic mem_rd_stb, mem_wr_stb, reboot_stb, save_stb, nvm_page_on, customer_nvm_on;
  logic [31:0] seed = 32'h8;
  logic [4:0] pg_code [6] = '{5'h0B, 5'h09, 5'h0B, 5'h0C, 5'h0B, 5'h0A};
  logic [1:0] pg_exp [6] = '{2'h0, 2'h2, 2'h3, 2'h2, 2'h3, 2'h0};
  logic [4:0] odd_code [4] = '{5'h1F, 5'h1A, 5'h02, 5'h10};
  int rd_cnt = 0, wr_cnt = 0, rb_cnt = 0, sv_cnt = 0;
  int n_fail = 0, cmp_count = 0;

  always #2 clk = ~clk;

  jtmap_host host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

  jtmap_tap DUT (.clk(clk), .resetn(resetn), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe), .mem_rd_data(mem_rd_data), .user_id(user_id), .bus_id(bus_id),
    .mem_addr(mem_addr), .mem_wr_data(mem_wr_data), .mem_rd_stb(mem_rd_stb),
    .mem_wr_stb(mem_wr_stb), .reboot_stb(reboot_stb), .save_stb(save_stb),
    .nvm_page_on(nvm_page_on), .customer_nvm_on(customer_nvm_on));

  // ==========================================================================
  // Expectations and helpers
  function automatic logic [7:0] mem_of(input logic [7:0] a);
    return a ^ 8'h5A;
  endfunction : mem_of

  function automatic logic [31:0] id_word();
    return {JTMAP_ID_VERSION, JTMAP_ID_PART, JTMAP_ID_MAKER, 1'b1};
  endfunction : id_word

  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xorshift

  task automatic rnd(output logic [31:0] r);
    r = xorshift();
  endtask : rnd

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic ir(input logic [4:0] code, input int brk);
    logic [31:0] q;
    host.scan(1'b1, 5, {27'h0, code}, brk, q);
    check(q, {27'h0, JTMAP_IR_CAPTURE});
  endtask : ir

  task automatic settle();
    repeat (10) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  // ==========================================================================
  // Memory side and strobe monitor
  always @(negedge clk) begin
    mem_rd_data <= mem_of(mem_addr);
  end

  always @(posedge clk) begin
    rd_cnt <= rd_cnt + (mem_rd_stb === 1'b1);
    wr_cnt <= wr_cnt + (mem_wr_stb === 1'b1);
    rb_cnt <= rb_cnt + (reboot_stb === 1'b1);
    sv_cnt <= sv_cnt + (save_stb === 1'b1);
    if (mem_wr_stb === 1'b1) begin
      last_wr <= mem_wr_data;
    end
  end

  initial begin
    #200000;
    n_fail++;
    summarize();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    logic [31:0] r, q, a, d;
    int n0, n1;
    rnd(r);
    user_id = r[7:0];
    bus_id = r[15:8];
    host.step(1'b1);
    repeat (2) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    host.step(1'b0);
    rnd(r);
    host.scan(1'b0, 32, r, -1, q);
    check(q, id_word());
    // bypass and undefined codes, with pauses
    for (int k = 0; k < 4; k++) begin
      ir(odd_code[k], k);
      rnd(r);
      host.scan(1'b0, 8, r, k + 1, q);
      check(q[7:0], {r[6:0], 1'b0});
    end
    rnd(r);
    @(negedge clk);
    user_id = r[7:0];
    bus_id = r[15:8];
    ir(JTMAP_IR_USERCODE, -1);
    host.scan(1'b0, 32, r, 5, q);
    check(q, {16'h0, r[15:8], r[7:0]});
    for (int k = 0; k < 3; k++) begin
      rnd(a);
      ir(JTMAP_IR_LOAD_ADDR, -1);
      host.scan(1'b0, 8, a, k + 2, q);
      settle();
      check(mem_addr, a[7:0]);
      ir(JTMAP_IR_WRITE_DATA, -1);
      rnd(d);
      n0 = wr_cnt;
      host.scan(1'b0, 8, d, -1, q);
      settle();
      check(wr_cnt - n0, 1);
      check(last_wr, d[7:0]);
      n1 = rd_cnt;
      ir(JTMAP_IR_READ_DATA, -1);
      settle();
      host.scan(1'b0, 8, d, -1, q);
      settle();
      check(q[7:0], mem_of(a[7:0]));
      check(rd_cnt - n1, 2);
    end
    for (int k = 0; k < 2; k++) begin
      n0 = rb_cnt;
      n1 = sv_cnt;
      ir(k ? JTMAP_IR_SAVE : JTMAP_IR_REBOOT, -1);
      settle();
      check(rb_cnt - n0, 1 - k);
      check(sv_cnt - n1, k);
    end
    // page flags, customer space refused while page off
    for (int k = 0; k < 6; k++) begin
      ir(pg_code[k], -1);
      settle();
      check({nvm_page_on, customer_nvm_on}, pg_exp[k]);
    end
    // select-IR with TMS high returns to reset
    ir(JTMAP_IR_BYPASS, -1);
    host.step(1'b1);
    host.step(1'b1);
    host.step(1'b1);
    host.step(1'b0);
    host.scan(1'b0, 32, 32'h0, -1, q);
    check(q, id_word());
    ir(JTMAP_IR_BYPASS, -1);
    host.step(1'b1);
    host.step(1'b0);
    host.step(1'b0);
    host.go_reset();
    host.scan(1'b0, 32, 32'h0, -1, q);
    check(q, id_word());
    check(host.oe_bad, 0);
    summarize();
  end
endmodule : jtmap_tap_tb
